// ==== nps_map.svh ====
`ifndef NPS_MAP_SVH
`define NPS_MAP_SVH
// Register word indices; byte address is four times the index
`define NPS_IDX_PDVSR     6'h08
`define NPS_IDX_PLEN      6'h09
`define NPS_IDX_PSEQ      6'h0a
`define NPS_IDX_NDVSR     6'h0b
`define NPS_IDX_NLEN      6'h0c
`define NPS_IDX_NSEQ      6'h0d
`define NPS_IDX_SWITCH    6'h0e
`define NPS_IDX_STATUS    6'h10
`define NPS_IDX_IRQ_STAT  6'h11
`define NPS_IDX_IRQ_MASK  6'h12
// Field positions in the switch register
`define NPS_SW_REQ_BIT    0
`define NPS_SW_FORCE_BIT  1
// Field positions in the status register
`define NPS_ST_SEL_BIT    0
`define NPS_ST_CP_BIT     1
`define NPS_ST_PEND_BIT   2
`define NPS_ST_LOCK_BIT   3
// Interrupt event bits
`define NPS_EV_COMMIT     0
`define NPS_EV_SWITCHED   1
`define NPS_EV_LOCKED     2
`define NPS_EV_LATE       3
`define NPS_EV_W          4
// Reset values
`define NPS_RST_PDVSR     5'h01
`define NPS_RST_NDVSR     7'h01
`define NPS_RST_LEN       3'h0
`define NPS_RST_SEQ       8'h00
// Boot core clock divisor from the crystal
`define NPS_BOOT_DIV      5'h09
// Frame syncs after the last divider write before switching
`define NPS_SWITCH_FS_MIN 2'h2
// Frame syncs allowed for the loop to lock
`define NPS_SETTLE_FS     2'h1
`endif

// ==== nps_pkg.sv ====
package nps_pkg;
   // Core clock source selector states
   typedef enum logic [1:0] {
      NPS_ST_XTAL,
      NPS_ST_DRAIN,
      NPS_ST_ARM,
      NPS_ST_PLL
   } nps_mux_state_e;
   // Register word index
   typedef logic [5:0] nps_idx_t;
endpackage

// ==== nps_nco_div.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "nps_map.svh"
// Fractional divider: counts input ticks in groups of dvsr or dvsr+1
module nps_nco_div #(
   parameter int DW = 5
) (
   input  wire logic          core_clk,
   input  wire logic          srst,
   input  wire logic          in_tick,    // One tick per source cycle
   input  wire logic [DW-1:0] dvsr,       // Integer divisor
   input  wire logic [2:0]    len_m1,     // Pattern length minus one
   input  wire logic [7:0]    seq,        // Divide pattern
   output logic               out_tick    // One pulse per group
);
   logic [DW:0] cnt_q;   // Ticks seen in current group
   logic [2:0]  idx_q;   // Pattern bit position
   wire  [2:0]  idx_eff; // Position clamped to pattern length
   wire         pat_bit; // Current pattern bit
   wire  [DW:0] div_w;   // Divide ratio of this group
   wire  [DW:0] cnt_nx;  // Count after this tick
   wire         last_w;  // Group ends on this tick

   initial begin
      if (DW < 2 || DW > 8) $error("nps_nco_div: DW out of range");
   end

   assign idx_eff = (idx_q > len_m1) ? len_m1 : idx_q;
   assign pat_bit = (len_m1 == 3'h0) ? 1'b0 : seq[idx_eff];
   assign div_w   = {1'b0, dvsr} + {{DW{1'b0}}, pat_bit};
   assign cnt_nx  = cnt_q + {{DW{1'b0}}, 1'b1};
   // Divide ratio of zero behaves as one
   assign last_w  = in_tick && (cnt_nx >= div_w);

   // Group counter and pattern walker
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_q    <= '0;
         idx_q    <= 3'h7;
         out_tick <= 1'b0;
      end else begin
         out_tick <= last_w;
         if (last_w) begin
            cnt_q <= '0;
            idx_q <= (idx_eff == 3'h0) ? len_m1 : idx_eff - 3'h1;
         end else if (in_tick) begin
            cnt_q <= cnt_nx;
         end
      end
   end
endmodule
`default_nettype wire

// ==== nps_clk_mux.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "nps_map.svh"
// Glitch free selector between crystal and loop clock enables
module nps_clk_mux (
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic xtal_en,   // Boot clock enable
   input  wire logic pll_en,    // Loop clock enable
   input  wire logic go,        // Permitted switch request
   output logic      clk_en,    // Selected core clock enable
   output logic      sel_pll,   // Loop clock is selected
   output logic      switched   // One pulse when switch completes
);
   nps_pkg::nps_mux_state_e st_q;
   nps_pkg::nps_mux_state_e st_d;
   wire                     pass_w;

   // Next state: finish the boot period, then wait for a loop edge
   always_comb begin
      st_d = st_q;
      case (st_q)
         nps_pkg::NPS_ST_XTAL:  if (go) st_d = nps_pkg::NPS_ST_DRAIN;
         nps_pkg::NPS_ST_DRAIN: if (xtal_en) st_d = nps_pkg::NPS_ST_ARM;
         nps_pkg::NPS_ST_ARM:   if (pll_en) st_d = nps_pkg::NPS_ST_PLL;
         default:               st_d = st_q;
      endcase
   end

   assign pass_w = ((st_q == nps_pkg::NPS_ST_XTAL || st_q == nps_pkg::NPS_ST_DRAIN) && xtal_en)
                 || (st_q == nps_pkg::NPS_ST_PLL && pll_en);

   // State and registered outputs
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_q     <= nps_pkg::NPS_ST_XTAL;
         clk_en   <= 1'b0;
         sel_pll  <= 1'b0;
         switched <= 1'b0;
      end else begin
         st_q     <= st_d;
         clk_en   <= pass_w;
         sel_pll  <= (st_d == nps_pkg::NPS_ST_PLL);
         switched <= (st_q == nps_pkg::NPS_ST_ARM) && pll_en;
      end
   end
endmodule
`default_nettype wire

// ==== nps_top.sv ====
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "nps_map.svh"
module nps_top (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        xtal_tick,
   input  wire logic        pll_output_clock,
   input  wire logic        frame_sync,
   input  wire logic        pll_lock_flag,
   output logic             ref_tick,
   output logic             fb_tick,
   output logic             sys_clk_en,
   output logic             sys_clk_sel_pll,
   output logic             cp_high,
   output logic             irq
);
   // Staging registers written by the host
   logic [4:0] pdvsr_q;
   logic [2:0] plen_q;
   logic [7:0] pseq_q;
   logic [6:0] ndvsr_q;
   logic [2:0] nlen_q;
   // Active registers seen by the dividers
   logic [4:0] a_pdvsr_q;
   logic [2:0] a_plen_q;
   logic [7:0] a_pseq_q;
   logic [6:0] a_ndvsr_q;
   logic [2:0] a_nlen_q;
   logic [7:0] a_nseq_q;
   // Control and status
   logic       force_q;     // Force bit from the switch register
   logic       req_q;       // Host switch request pending
   logic [1:0] fs_cnt_q;    // Frame syncs since last commit
   logic       lock_d1_q;   // Lock flag one cycle ago
   logic       settle_q;    // Waiting for lock after commit
   logic [`NPS_EV_W-1:0] ist_q;   // Sticky event bits
   logic [`NPS_EV_W-1:0] imask_q; // Event enables
   wire        xtal9_tick;  // Boot core clock enable
   wire        mux_sel;     // Loop clock selected
   wire        mux_done;    // Switch completed
   wire        mux_en;      // Selected clock enable

   // Bus decode
   wire              acc_w   = (avs_read || avs_write) && avs_waitrequest;
   wire              done_w  = (avs_read || avs_write) && !avs_waitrequest;
   wire              wr_w    = avs_write && done_w && avs_byteenable[0];
   wire [7:0]        wd_w    = avs_writedata[7:0];
   wire nps_pkg::nps_idx_t idx_w = avs_address[7:2];
   wire              commit_w;
   wire              go_w;
   wire              late_w;
   wire              lock_rise_w;
   wire [`NPS_EV_W-1:0] ev_w;
   wire [`NPS_EV_W-1:0] clr_w;
   wire [31:0]       rd_w;

   // Address match for one register index
   function automatic logic hit(input nps_pkg::nps_idx_t a, input nps_pkg::nps_idx_t r);
      hit = (a == r);
   endfunction

   assign commit_w = wr_w && hit(idx_w, `NPS_IDX_NSEQ);
   assign go_w = req_q && (fs_cnt_q >= `NPS_SWITCH_FS_MIN);
   assign late_w = settle_q && frame_sync && (fs_cnt_q >= `NPS_SETTLE_FS) && !pll_lock_flag;
   assign lock_rise_w = pll_lock_flag && !lock_d1_q;
   assign ev_w = {late_w, lock_rise_w, mux_done, commit_w};
   assign clr_w = (wr_w && hit(idx_w, `NPS_IDX_IRQ_STAT)) ? wd_w[`NPS_EV_W-1:0]
                                                          : {`NPS_EV_W{1'b0}};

   // Read data selection
   assign rd_w =
      hit(idx_w, `NPS_IDX_PDVSR)    ? {27'h0, pdvsr_q} :
      hit(idx_w, `NPS_IDX_PLEN)     ? {29'h0, plen_q} :
      hit(idx_w, `NPS_IDX_PSEQ)     ? {24'h0, pseq_q} :
      hit(idx_w, `NPS_IDX_NDVSR)    ? {25'h0, ndvsr_q} :
      hit(idx_w, `NPS_IDX_NLEN)     ? {29'h0, nlen_q} :
      hit(idx_w, `NPS_IDX_NSEQ)     ? {24'h0, a_nseq_q} :
      hit(idx_w, `NPS_IDX_SWITCH)   ? {30'h0, force_q, req_q} :
      hit(idx_w, `NPS_IDX_STATUS)   ? {28'h0, pll_lock_flag, req_q, cp_high, sys_clk_sel_pll} :
      hit(idx_w, `NPS_IDX_IRQ_STAT) ? {28'h0, ist_q} :
      hit(idx_w, `NPS_IDX_IRQ_MASK) ? {28'h0, imask_q} :
      32'h0000_0000;

   // Bus handshake: one wait state, then the access completes
   always_ff @(posedge core_clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= !acc_w;
         if (acc_w) begin
            avs_readdata <= rd_w;
         end
      end
   end

   // Staging registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pdvsr_q <= `NPS_RST_PDVSR;
         plen_q  <= `NPS_RST_LEN;
         pseq_q  <= `NPS_RST_SEQ;
         ndvsr_q <= `NPS_RST_NDVSR;
         nlen_q  <= `NPS_RST_LEN;
      end else if (wr_w) begin
         if (hit(idx_w, `NPS_IDX_PDVSR)) begin
            pdvsr_q <= wd_w[4:0];
         end else if (hit(idx_w, `NPS_IDX_PLEN)) begin
            plen_q <= wd_w[2:0];
         end else if (hit(idx_w, `NPS_IDX_PSEQ)) begin
            pseq_q <= wd_w;
         end else if (hit(idx_w, `NPS_IDX_NDVSR)) begin
            ndvsr_q <= wd_w[6:0];
         end else if (hit(idx_w, `NPS_IDX_NLEN)) begin
            nlen_q <= wd_w[2:0];
         end
      end
   end

   // Active set loads only on the final write
   always_ff @(posedge core_clk) begin
      if (srst) begin
         a_pdvsr_q <= `NPS_RST_PDVSR;
         a_plen_q  <= `NPS_RST_LEN;
         a_pseq_q  <= `NPS_RST_SEQ;
         a_ndvsr_q <= `NPS_RST_NDVSR;
         a_nlen_q  <= `NPS_RST_LEN;
         a_nseq_q  <= `NPS_RST_SEQ;
      end else if (commit_w) begin
         a_pdvsr_q <= pdvsr_q;
         a_plen_q  <= plen_q;
         a_pseq_q  <= pseq_q;
         a_ndvsr_q <= ndvsr_q;
         a_nlen_q  <= nlen_q;
         a_nseq_q  <= wd_w;
      end
   end

   // Switch request and force bit
   always_ff @(posedge core_clk) begin
      if (srst) begin
         req_q   <= 1'b0;
         force_q <= 1'b0;
      end else begin
         if (wr_w && hit(idx_w, `NPS_IDX_SWITCH)) begin
            force_q <= wd_w[`NPS_SW_FORCE_BIT];
         end
         if (wr_w && hit(idx_w, `NPS_IDX_SWITCH) && wd_w[`NPS_SW_REQ_BIT]) begin
            req_q <= 1'b1;
         end else if (go_w) begin
            req_q <= 1'b0;
         end
      end
   end

   // Frame syncs counted since the last commit, saturating
   always_ff @(posedge core_clk) begin
      if (srst) begin
         fs_cnt_q <= 2'h0;
      end else if (commit_w) begin
         fs_cnt_q <= 2'h0;
      end else if (frame_sync && fs_cnt_q != 2'h3) begin
         fs_cnt_q <= fs_cnt_q + 2'h1;
      end
   end

   // Charge pump boost and settle watch
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cp_high   <= 1'b1;
         settle_q  <= 1'b0;
         lock_d1_q <= 1'b0;
      end else begin
         lock_d1_q <= pll_lock_flag;
         if (pll_lock_flag || force_q) begin
            cp_high <= 1'b0;
         end else if (commit_w) begin
            cp_high <= 1'b1;
         end
         if (commit_w) begin
            settle_q <= 1'b1;
         end else if (pll_lock_flag || late_w) begin
            settle_q <= 1'b0;
         end
      end
   end

   // Sticky events, set wins over clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ist_q   <= {`NPS_EV_W{1'b0}};
         imask_q <= {`NPS_EV_W{1'b0}};
         irq     <= 1'b0;
      end else begin
         ist_q <= (ist_q & ~clr_w) | ev_w;
         if (wr_w && hit(idx_w, `NPS_IDX_IRQ_MASK)) begin
            imask_q <= wd_w[`NPS_EV_W-1:0];
         end
         irq <= |(((ist_q & ~clr_w) | ev_w) & imask_q);
      end
   end

   nps_nco_div #(
      .DW(5)
   ) u_boot_div (
      .core_clk(core_clk),
      .srst    (srst),
      .in_tick (xtal_tick),
      .dvsr    (`NPS_BOOT_DIV),
      .len_m1  (3'h0),
      .seq     (8'h00),
      .out_tick(xtal9_tick)
   );

   nps_nco_div #(
      .DW(5)
   ) u_prescaler (
      .core_clk(core_clk),
      .srst    (srst),
      .in_tick (xtal_tick),
      .dvsr    (a_pdvsr_q),
      .len_m1  (a_plen_q),
      .seq     (a_pseq_q),
      .out_tick(ref_tick)
   );

   nps_nco_div #(
      .DW(7)
   ) u_feedback (
      .core_clk(core_clk),
      .srst    (srst),
      .in_tick (pll_output_clock),
      .dvsr    (a_ndvsr_q),
      .len_m1  (a_nlen_q),
      .seq     (a_nseq_q),
      .out_tick(fb_tick)
   );

   nps_clk_mux u_mux (
      .core_clk(core_clk),
      .srst    (srst),
      .xtal_en (xtal9_tick),
      .pll_en  (pll_output_clock),
      .go      (go_w),
      .clk_en  (mux_en),
      .sel_pll (mux_sel),
      .switched(mux_done)
   );

   // Top outputs from flip-flops
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sys_clk_en      <= 1'b0;
         sys_clk_sel_pll <= 1'b0;
      end else begin
         sys_clk_en      <= mux_en;
         sys_clk_sel_pll <= mux_sel;
      end
   end
endmodule
`default_nettype wire

// ==== nps_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Crystal, loop oscillator and frame timing seen by the block
module nps_far_model #(
   parameter int FS_PER = 150
) (
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic lock_en,          // Bench decides when lock shows
   output logic      xtal_tick,
   output logic      pll_output_clock,
   output logic      frame_sync,
   output logic      pll_lock_flag
);
   logic [7:0] cnt_q;                  // Frame position
   logic       ph_q;                   // Loop oscillator phase
   // Free running frame and oscillator counters
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_q <= 8'h00;
         ph_q  <= 1'b0;
      end else begin
         ph_q  <= !ph_q;
         cnt_q <= (cnt_q == 8'(FS_PER - 1)) ? 8'h00 : cnt_q + 8'h01;
      end
   end
   assign xtal_tick        = 1'b1;
   assign pll_output_clock = ph_q;
   assign frame_sync       = (cnt_q == 8'(FS_PER - 1));
   assign pll_lock_flag    = lock_en;
endmodule
`default_nettype wire

// ==== nps_top_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module nps_top_chk (
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        xtal_tick,
   input wire logic        pll_output_clock,
   input wire logic        frame_sync,
   input wire logic        pll_lock_flag,
   input wire logic        ref_tick,
   input wire logic        fb_tick,
   input wire logic        sys_clk_en,
   input wire logic        sys_clk_sel_pll,
   input wire logic        cp_high,
   input wire logic        irq
);
   logic [2:0] fs_q;                   // Syncs since last commit
   logic       req_q;                  // Switch was requested
   logic       frc_q;                  // Force bit as written
   wire        wdone = avs_write && !avs_waitrequest && avs_byteenable[0];
   wire  [5:0] idx   = avs_address[7:2];
   // Track commits, requests and force writes
   always_ff @(posedge core_clk) begin
      if (srst) begin
         fs_q  <= 3'h0;
         req_q <= 1'b0;
         frc_q <= 1'b0;
      end else begin
         if (wdone && idx == 6'h0d) begin
            fs_q <= 3'h0;
         end else if (frame_sync && fs_q < 3'h3) begin
            fs_q <= fs_q + 3'h1;
         end
         if (wdone && idx == 6'h0e) begin
            req_q <= req_q | avs_writedata[0];
            frc_q <= avs_writedata[1];
         end
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("access not answered next cycle");
   AST_BOOT_DIV: assert property (!req_q && sys_clk_en |=> !sys_clk_en [*8] ##1 sys_clk_en)
      else $error("boot clock not crystal over nine");
   AST_REQ_FIRST: assert property ($rose(sys_clk_sel_pll) |-> req_q)
      else $error("switch without request");
   AST_TWO_SYNCS: assert property ($rose(sys_clk_sel_pll) |-> fs_q >= 3'h2)
      else $error("switch before second frame sync");
   AST_NO_RUNT: assert property (sys_clk_en |=> !sys_clk_en)
      else $error("core clock enable glitch");
   AST_SEL_HOLD: assert property (sys_clk_sel_pll |=> sys_clk_sel_pll)
      else $error("source selection fell back");
   AST_LOCK_DROP: assert property (pll_lock_flag |-> ##[1:2] !cp_high)
      else $error("pump current high after lock");
   AST_CP_CAUSE: assert property ($fell(cp_high) |-> $past(pll_lock_flag) || frc_q)
      else $error("pump current dropped early");
endmodule
bind nps_top nps_top_chk u_nps_top_chk (.*);
`default_nettype wire

// ==== nps_top_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module nps_top_bench;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic        lock_en = 1'b0;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest, xtal_tick, pll_output_clock, frame_sync, pll_lock_flag;
   wire         ref_tick, fb_tick, sys_clk_en, sys_clk_sel_pll, cp_high, irq;
   int          err_total = 0;
   int          checked = 0;
   int          cyc = 0;
   int          m[16];                 // Measured pulse intervals
   logic [31:0] rd;                    // Last read data
   nps_top u_nps_top (.*);
   nps_far_model u_nps_far_model (.*);
   // Clock
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
      end
   endtask
   // One bus access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      avs_address   <= {a, 2'b00};
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= {24'h0, d};
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask
   function automatic logic pick(input int s);
      return (s == 0) ? ref_tick : (s == 1) ? fb_tick : sys_clk_en;
   endfunction
   // Intervals of n pulses, two settling pulses skipped
   task automatic meas(input int s, input int n);
      int c = 0;
      int k = -2;
      while (k < n) begin
         @(posedge core_clk);
         c++;
         if (pick(s) === 1'b1) begin
            if (k >= 0) m[k] = c;
            k++;
            c = 0;
         end
      end
   endtask
   // Intervals match some rotation of the walk from len down to 0
   function automatic logic rot_ok(int dv, int len, logic [7:0] sq, int sc, int n);
      logic ok;
      for (int o = 0; o <= len; o++) begin
         ok = 1'b1;
         for (int k = 0; k < n; k++) begin
            if (m[k] != sc * (dv + ((len == 0) ? 0 : sq[len - (o + k) % (len + 1)]))) ok = 1'b0;
         end
         if (ok) return 1'b1;
      end
      return 1'b0;
   endfunction
   initial begin
      int pd, pl, nd, nl, opd, opl, n;
      logic [7:0] ps, ns, ops;
      void'($urandom(68));
      opd = 1;
      opl = 0;
      ops = 8'h00;
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      chk("waitreq", 1, avs_waitrequest);
      chk("cp_rst", 1, cp_high);
      meas(2, 3);
      for (int k = 0; k < 3; k++) chk("boot", 9, m[k]);
      bus(0, 6'h20, 8'h00);
      chk("unmapped", 0, rd);
      avs_byteenable <= 4'h0;
      bus(1, 6'h08, 8'h05);
      avs_byteenable <= 4'hf;
      bus(0, 6'h08, 8'h00);
      chk("be_off", 1, rd);
      for (int i = 0; i < 3; i++) begin
         pd = 2 + $urandom % 30;
         pl = (i == 0) ? 7 : (i == 1) ? 0 : $urandom % 8;
         ps = 8'($urandom);
         nd = 2 + $urandom % 126;
         nl = $urandom % 8;
         ns = 8'($urandom);
         bus(1, 6'h08, 8'(pd));
         meas(0, 6);
         chk("staged", 1, 32'(rot_ok(opd, opl, ops, 1, 6)));
         bus(0, 6'h08, 8'h00);
         chk("pdvsr", pd, rd);
         bus(1, 6'h09, 8'(pl));
         bus(1, 6'h0a, ps);
         bus(1, 6'h0b, 8'(nd));
         bus(1, 6'h0c, 8'(nl));
         bus(1, 6'h0d, ns);
         chk("cp_commit", 1, cp_high);
         meas(0, 16);
         chk("ref_seq", 1, 32'(rot_ok(pd, pl, ps, 1, 16)));
         meas(1, 16);
         chk("fb_seq", 1, 32'(rot_ok(nd, nl, ns, 2, 16)));
         opd = pd;
         opl = pl;
         ops = ps;
      end
      lock_en <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("cp_lock", 0, cp_high);
      lock_en <= 1'b0;
      bus(1, 6'h12, 8'h02);
      chk("irq_mask", 0, irq);
      bus(1, 6'h0d, ns);
      chk("cp_again", 1, cp_high);
      bus(1, 6'h0e, 8'h03);
      repeat (3) @(posedge core_clk);
      chk("cp_force", 0, cp_high);
      chk("sel_early", 0, sys_clk_sel_pll);
      n = 0;
      while (sys_clk_sel_pll !== 1'b1) begin
         @(posedge core_clk);
         if (frame_sync === 1'b1) n++;
      end
      chk("syncs", 1, 32'(n >= 2));
      @(posedge core_clk);
      chk("irq_set", 1, irq);
      bus(0, 6'h11, 8'h00);
      chk("irq_stat", 1, rd[1]);
      bus(1, 6'h11, 8'h02);
      @(posedge core_clk);
      chk("irq_clr", 0, irq);
      meas(2, 4);
      for (int k = 0; k < 4; k++) chk("pll_en", 2, m[k]);
      srst <= 1'b1;
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      chk("sel_rst", 0, sys_clk_sel_pll);
      meas(2, 2);
      chk("boot2", 9, m[1]);
      print_verdict();
   end
endmodule
`default_nettype wire
